// [iiec_fifo_sink.sv]
// Event FIFO stand-in that takes events from the block
`timescale 1ns/10ps
module iiec_fifo_sink (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Async reset, high
  input  wire logic       stall_i, // Hold off acceptance
  input  wire logic       valid_i, // Event offered
  input  wire logic [4:0] code_i,  // Event code
  output logic            ready_o, // Space available
  output logic [7:0]      count_o, // Events taken
  output logic [4:0]      last_o   // Last code taken
);
  // Ready unless told to stall
  assign ready_o = ~stall_i;
  // Count and keep each event taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= 8'h00;
      last_o  <= 5'h00;
    end else if (valid_i && ready_o) begin // Handshake completes
      count_o <= count_o + 8'h01;
      last_o  <= code_i;
    end
  end
endmodule : iiec_fifo_sink

// [iiec_input_cell.sv]
// One general-purpose input: level detect, sticky flag and event pending bit
`timescale 1ns/10ps
module iiec_input_cell (
  input  wire logic clk_i,      // System clock
  input  wire logic rst_i,      // Asynchronous reset, active high
  input  wire logic row_i,      // Row pin level
  input  wire logic polarity_i, // 1 = active high, 0 = active low
  input  wire logic route_i,    // 1 = event mode
  input  wire logic clear_i,    // Flag clear request
  input  wire logic grant_i,    // Pending event taken
  output logic      active_o,   // Pin at its configured level
  output logic      flag_o,     // Sticky interrupt flag
  output logic      pending_o   // Event waiting for the FIFO
);
  // ****************************************************
  // Level condition
  // ****************************************************
  logic prev_ff;    // Level condition one cycle ago
  logic flag_ff;    // Sticky flag
  logic pending_ff; // Event pending

  // Polarity selects which pin level counts as active
  assign active_o  = polarity_i ? row_i : ~row_i;
  assign flag_o    = flag_ff;
  // Leaving event mode hides a stale pending bit before it clears
  assign pending_o = pending_ff & route_i;

  // Previous level for change detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= active_o;
    end
  end

  // Flag sets while the level holds outside event mode; set beats clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else if (active_o && !route_i) begin
      flag_ff <= 1'b1;
    end else if (clear_i) begin
      flag_ff <= 1'b0;
    end
  end

  // Activity in event mode queues one event; new activity beats grant
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
    end else if (route_i && (active_o != prev_ff)) begin
      pending_ff <= 1'b1;
    end else if (grant_i || !route_i) begin
      pending_ff <= 1'b0;
    end
  end
endmodule : iiec_input_cell

// [iiec_pkg.sv]
// Shared constants for the input interrupt and event configuration block
package iiec_pkg;
  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] ADDR_POL_A   = 8'h1B; // Polarity, inputs 1-6
  localparam logic [7:0] ADDR_POL_B   = 8'h1C; // Polarity, inputs 7-11
  localparam logic [7:0] ADDR_ROUTE_A = 8'h1D; // Event route, inputs 1-6
  localparam logic [7:0] ADDR_ROUTE_B = 8'h1E; // Event route, inputs 7-11
  localparam logic [7:0] ADDR_GATE_A  = 8'h1F; // Irq gate, inputs 1-6
  localparam logic [7:0] ADDR_GATE_B  = 8'h20; // Irq gate, inputs 7-11
  // ****************************************************
  // Field layout and reset values
  // ****************************************************
  localparam int         NUM_IN       = 11;    // Inputs 1..11
  localparam int         NUM_A        = 6;     // Inputs held in the A registers
  localparam int         NUM_B        = 5;     // Inputs held in the B registers
  localparam int         IDX_W        = 4;     // Width of an input index
  localparam logic [7:0] REG_RESET    = 8'h00; // Reset value of every register
  localparam logic [7:0] READ_ZERO    = 8'h00; // Unmapped and reserved read value
endpackage : iiec_pkg

// [iiec_top.sv]
// Input interrupt polarity, event routing and summary interrupt gating
// What this block does
// - Polarity bits 0-4 for inputs 7-11
// - Flag sets while row pin at level, not in event mode
// - Polarity bits 0-5 for inputs 1-6
// - Event route bits 0-5, inputs 1-6
// - Event route bits 0-4, inputs 7-11
// - Event mode activity raises event interrupt
// - Event mode never raises summary interrupt
// - Event mode inputs eligible for unlock
// - Gate bits 0-5 pass flags to summary
// - Gate bit zero blocks that input's flag
// - Gate bits 0-4 for inputs 7-11
`timescale 1ns/10ps
module iiec_top #(
  parameter int NUM_IN = iiec_pkg::NUM_IN // Number of inputs
) (
  input  wire logic                      clk_i,               // System clock
  input  wire logic                      rst_i,               // Async reset, high
  input  wire logic [NUM_IN-1:0]         row_i,               // Row pins 0..10
  input  wire logic [7:0]                reg_addr_i,          // Register address
  input  wire logic                      reg_wr_i,            // Write strobe
  input  wire logic [7:0]                reg_wdata_i,         // Write data
  input  wire logic                      reg_rd_i,            // Read strobe
  output logic      [7:0]                reg_rdata_o,         // Read data
  output logic                           reg_hit_o,           // Address is mapped
  input  wire logic [NUM_IN-1:0]         flag_clear_i,        // Flag clear requests
  output logic [NUM_IN-1:0]              irq_flag_o,          // Per-input flags
  output logic                           summary_input_irq_o, // Summary interrupt
  output logic                           event_valid_o,       // Event to FIFO
  output logic [iiec_pkg::IDX_W:0]       event_code_o,        // {level, index}
  input  wire logic                      event_ready_i,       // FIFO accepts
  output logic                           event_irq_o,         // Event interrupt pulse
  output logic [NUM_IN-1:0]              unlock_src_o         // Unlock-eligible inputs
);
  localparam int NA = iiec_pkg::NUM_A;
  localparam int NB = iiec_pkg::NUM_B;
  localparam int IW = iiec_pkg::IDX_W;

  // ****************************************************
  // Register decode
  // ****************************************************
  logic [NUM_IN-1:0] pol_ff;     // Polarity bits
  logic [NUM_IN-1:0] route_ff;   // Event route bits
  logic [NUM_IN-1:0] gate_ff;    // Interrupt gate bits
  logic [7:0]        rdata_ff;   // Registered read data

  // True when the address selects the given register
  function automatic logic sel(input logic [7:0] addr, input logic [7:0] ofs);
    sel = (addr == ofs);
  endfunction : sel

  assign reg_hit_o = sel(reg_addr_i, iiec_pkg::ADDR_POL_A)   |
                     sel(reg_addr_i, iiec_pkg::ADDR_POL_B)   |
                     sel(reg_addr_i, iiec_pkg::ADDR_ROUTE_A) |
                     sel(reg_addr_i, iiec_pkg::ADDR_ROUTE_B) |
                     sel(reg_addr_i, iiec_pkg::ADDR_GATE_A)  |
                     sel(reg_addr_i, iiec_pkg::ADDR_GATE_B);

  // Polarity registers; only implemented bits are stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pol_ff <= NUM_IN'(iiec_pkg::REG_RESET);
    end else if (reg_wr_i && sel(reg_addr_i, iiec_pkg::ADDR_POL_A)) begin
      pol_ff[NA-1:0] <= reg_wdata_i[NA-1:0];
    end else if (reg_wr_i && sel(reg_addr_i, iiec_pkg::ADDR_POL_B)) begin
      pol_ff[NUM_IN-1:NA] <= reg_wdata_i[NB-1:0];
    end
  end

  // Event route registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_ff <= NUM_IN'(iiec_pkg::REG_RESET);
    end else if (reg_wr_i && sel(reg_addr_i, iiec_pkg::ADDR_ROUTE_A)) begin
      route_ff[NA-1:0] <= reg_wdata_i[NA-1:0];
    end else if (reg_wr_i && sel(reg_addr_i, iiec_pkg::ADDR_ROUTE_B)) begin
      route_ff[NUM_IN-1:NA] <= reg_wdata_i[NB-1:0];
    end
  end

  // Interrupt gate registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_ff <= NUM_IN'(iiec_pkg::REG_RESET);
    end else if (reg_wr_i && sel(reg_addr_i, iiec_pkg::ADDR_GATE_A)) begin
      gate_ff[NA-1:0] <= reg_wdata_i[NA-1:0];
    end else if (reg_wr_i && sel(reg_addr_i, iiec_pkg::ADDR_GATE_B)) begin
      gate_ff[NUM_IN-1:NA] <= reg_wdata_i[NB-1:0];
    end
  end

  // Read mux; reserved bits and unmapped addresses give zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= iiec_pkg::READ_ZERO;
    end else if (reg_rd_i) begin
      rdata_ff <= iiec_pkg::READ_ZERO;
      if (sel(reg_addr_i, iiec_pkg::ADDR_POL_A))   rdata_ff[NA-1:0] <= pol_ff[NA-1:0];
      if (sel(reg_addr_i, iiec_pkg::ADDR_POL_B))   rdata_ff[NB-1:0] <= pol_ff[NUM_IN-1:NA];
      if (sel(reg_addr_i, iiec_pkg::ADDR_ROUTE_A)) rdata_ff[NA-1:0] <= route_ff[NA-1:0];
      if (sel(reg_addr_i, iiec_pkg::ADDR_ROUTE_B)) rdata_ff[NB-1:0] <= route_ff[NUM_IN-1:NA];
      if (sel(reg_addr_i, iiec_pkg::ADDR_GATE_A))  rdata_ff[NA-1:0] <= gate_ff[NA-1:0];
      if (sel(reg_addr_i, iiec_pkg::ADDR_GATE_B))  rdata_ff[NB-1:0] <= gate_ff[NUM_IN-1:NA];
    end
  end
  assign reg_rdata_o = rdata_ff;

  // ****************************************************
  // Per-input cells
  // ****************************************************
  logic [NUM_IN-1:0] active;  // Level condition met
  logic [NUM_IN-1:0] flag;    // Sticky flags
  logic [NUM_IN-1:0] pending; // Events waiting
  logic [NUM_IN-1:0] grant;   // One-hot event take

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      iiec_input_cell u_cell (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .row_i      (row_i[gi]),
        .polarity_i (pol_ff[gi]),
        .route_i    (route_ff[gi]),
        .clear_i    (flag_clear_i[gi]),
        .grant_i    (grant[gi]),
        .active_o   (active[gi]),
        .flag_o     (flag[gi]),
        .pending_o  (pending[gi])
      );
    end
  endgenerate
  assign irq_flag_o   = flag;
  assign unlock_src_o = route_ff;

  // ****************************************************
  // Summary interrupt
  // ****************************************************
  logic              summary_ff;   // Registered summary
  logic [NUM_IN-1:0] contrib;      // Inputs driving the summary

  // Flag, level and gate all needed; event mode inputs excluded
  assign contrib = flag & active & gate_ff & ~route_ff;

  // Summary follows the gated flags one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      summary_ff <= 1'b0;
    end else begin
      summary_ff <= |contrib;
    end
  end
  assign summary_input_irq_o = summary_ff;

  // ****************************************************
  // Event output to the FIFO
  // ****************************************************
  logic          evv_ff;    // Event valid
  logic [IW:0]   code_ff;   // Event code
  logic          evirq_ff;  // Event interrupt pulse
  logic          load;      // Take a pending event
  logic [IW-1:0] pick;      // Lowest pending index

  // Lowest numbered pending input wins
  always_comb begin
    pick  = '0;
    grant = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (pending[i]) pick = IW'(i);
    end
    if (load) grant[pick] = 1'b1;
  end
  assign load = (|pending) && (!evv_ff || event_ready_i);

  // Output slot stalls while the FIFO refuses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evv_ff  <= 1'b0;
      code_ff <= '0;
    end else if (load) begin
      evv_ff  <= 1'b1;
      code_ff <= {active[pick], pick};
    end else if (event_ready_i) begin
      evv_ff  <= 1'b0;
    end
  end

  // Each queued event raises the event interrupt
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evirq_ff <= 1'b0;
    end else begin
      evirq_ff <= load;
    end
  end
  assign event_valid_o = evv_ff;
  assign event_code_o  = code_ff;
  assign event_irq_o   = evirq_ff;

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence s_stall;
    evv_ff && !event_ready_i;
  endsequence

  a_flag_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (active[0] && !route_ff[0]) |=> flag[0])
    else $error("flag did not set at active level");
  a_summary_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (|contrib) |=> summary_input_irq_o)
    else $error("summary missed a gated flag");
  a_summary_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    summary_input_irq_o |-> $past(|(flag & active & gate_ff & ~route_ff)))
    else $error("summary without a cause");
  a_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (gate_ff == '0) ##1 (gate_ff == '0) |-> !summary_input_irq_o)
    else $error("summary while all gates off");
  a_event_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    load |=> event_irq_o && event_valid_o)
    else $error("event taken without interrupt");
  a_event_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stall |=> evv_ff && $stable(code_ff))
    else $error("event dropped under stall");
  a_event_route: assert property (@(posedge clk_i) disable iff (rst_i)
    load |-> route_ff[pick])
    else $error("event from input not in event mode");
  a_pol_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == iiec_pkg::ADDR_POL_B)
      |=> pol_ff[NUM_IN-1:NA] == $past(reg_wdata_i[NB-1:0]))
    else $error("polarity B write lost");
  a_rsv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == iiec_pkg::ADDR_GATE_B) |=> reg_rdata_o[7:NB] == '0)
    else $error("reserved bits read nonzero");
endmodule : iiec_top

// [tb_input_interrupt_event_config.sv]
// Self-checking testbench for the input interrupt and event block
`timescale 1ns/10ps
module tb_input_interrupt_event_config;
  // ****************************************************
  // Signals
  // ****************************************************
  logic        clk_i = 1'b0;      // 20 MHz clock
  logic        rst_i = 1'b1;      // Reset
  logic [10:0] row_i = 11'h03F;   // Inputs 1-6 high, 7-11 low
  logic [7:0]  addr  = 8'h00;     // Register address
  logic        wr    = 1'b0;      // Write strobe
  logic [7:0]  wdata = 8'h00;     // Write data
  logic        rd    = 1'b0;      // Read strobe
  logic [7:0]  rdata;             // Read data
  logic        hit;               // Mapped address
  logic [10:0] clr   = 11'h000;   // Flag clears
  logic [10:0] flag;              // Flags
  logic        summ;              // Summary interrupt
  logic        ev_valid;          // Event offered
  logic [4:0]  ev_code;           // Event code
  logic        ev_ready;          // Sink ready
  logic        ev_irq;            // Event interrupt
  logic [10:0] unlock;            // Unlock sources
  logic        stall = 1'b0;      // Sink stall
  logic [7:0]  taken;             // Events taken
  logic [4:0]  last;              // Last code taken
  int          num_errors = 0;    // Mismatches
  int          samples_checked = 0; // Comparisons
  always #25 clk_i = ~clk_i;
  // ****************************************************
  // Instances
  // ****************************************************
  iiec_top u_iiec_top (.clk_i(clk_i), .rst_i(rst_i), .row_i(row_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .flag_clear_i(clr), .irq_flag_o(flag), .summary_input_irq_o(summ),
    .event_valid_o(ev_valid), .event_code_o(ev_code), .event_ready_i(ev_ready),
    .event_irq_o(ev_irq), .unlock_src_o(unlock));
  iiec_fifo_sink u_iiec_fifo_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .valid_i(ev_valid), .code_i(ev_code), .ready_o(ev_ready), .count_o(taken),
    .last_o(last));
  // ****************************************************
  // Tasks
  // ****************************************************
  // Compare and count
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One register write
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a; wdata = d; wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : wreg
  // One register read, data settled one edge later
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr = a; rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    d = rdata;
  endtask : rreg
  // Idle cycles
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  // Reset values, access, reserved bits, unmapped place
  task automatic test_regs;
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      rreg(8'h1B + 8'(i), d);
      check("reset value", 16'h0000, {8'h00, d});
      wreg(8'h1B + 8'(i), 8'hFF);
      rreg(8'h1B + 8'(i), d);
      check("readback", (i % 2 == 0) ? 16'h003F : 16'h001F, {8'h00, d});
      check("mapped hit", 16'h0001, {15'h0000, hit});
      wreg(8'h1B + 8'(i), 8'h00);
    end
    wreg(8'h21, 8'hFF);
    rreg(8'h21, d);
    check("unmapped read", 16'h0000, {8'h00, d});
    check("unmapped hit", 16'h0000, {15'h0000, hit});
    $display("test_regs done");
  endtask : test_regs
  // Level flags gated onto the summary, low and high polarity
  task automatic test_summary;
    wreg(iiec_pkg::ADDR_GATE_A, 8'h01);
    wreg(iiec_pkg::ADDR_POL_B, 8'h01);
    wreg(iiec_pkg::ADDR_GATE_B, 8'h01);
    // All pins inactive, then drop flags left by earlier register tests
    row_i = 11'h7BF;
    clr   = 11'h7FF;
    idle(1);
    clr   = 11'h000;
    row_i[0] = 1'b0;
    idle(1);
    check("flag input 1", 16'h0001, {5'h00, flag});
    idle(1);
    check("summary low pol", 16'h0001, {15'h0000, summ});
    row_i[0] = 1'b1;
    idle(2);
    check("summary level drop", 16'h0000, {15'h0000, summ});
    clr = 11'h7FF;
    row_i[6] = 1'b1;
    idle(1);
    clr = 11'h000;
    idle(2);
    check("flag input 7", 16'h0040, {5'h00, flag});
    check("summary high pol", 16'h0001, {15'h0000, summ});
    wreg(iiec_pkg::ADDR_GATE_B, 8'h00);
    idle(1);
    check("summary gated off", 16'h0000, {15'h0000, summ});
    row_i[6] = 1'b0;
    clr = 11'h7FF;
    idle(1);
    clr = 11'h000;
    $display("test_summary done");
  endtask : test_summary
  // Routed input makes events, never the summary
  task automatic test_event;
    int n;
    wreg(iiec_pkg::ADDR_ROUTE_A, 8'h01);
    check("unlock sources", 16'h0001, {5'h00, unlock});
    stall = 1'b1;
    row_i[0] = 1'b0;
    n = 0;
    while (ev_valid !== 1'b1 && n < 10) begin
      idle(1);
      n++;
    end
    if (n == 10) begin
      num_errors++;
      $display("[ERR] event valid expected 1 seen %b", ev_valid);
      conclude();
    end
    check("event irq", 16'h0001, {15'h0000, ev_irq});
    check("event code", 16'h0010, {11'h000, ev_code});
    idle(1);
    check("event irq pulse", 16'h0000, {15'h0000, ev_irq});
    check("valid held", 16'h0001, {15'h0000, ev_valid});
    check("no summary", 16'h0000, {15'h0000, summ});
    check("no flag", 16'h0000, {5'h00, flag});
    stall = 1'b0;
    row_i[0] = 1'b1;
    idle(5);
    check("events taken", 16'h0002, {8'h00, taken});
    check("last code", 16'h0000, {11'h000, last});
    wreg(iiec_pkg::ADDR_ROUTE_B, 8'h10);
    check("unlock input 11", 16'h0401, {5'h00, unlock});
    $display("test_event done");
  endtask : test_event
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    idle(10);
    rst_i = 1'b0;
    test_regs();
    test_summary();
    test_event();
    conclude();
  end
endmodule : tb_input_interrupt_event_config
